// *** logic/link_fair_map.vh ***
/*
 constants for the link insertion fairness arbiter: counter sizes,
 reset values, packet kind codes, transmit source codes, register offsets.
 assumes inclusion by the arbiter and its counter bank only.
*/
`ifndef LINK_FAIR_MAP_VH
`define LINK_FAIR_MAP_VH

// rate measurement
`define UNIT_COUNT 32
`define UNIT_ID_W 5
`define UNIT_CNT_W 3
`define TOTAL_CNT_W 8
`define DENOM_RESET 8'h01

// insertion pacing
`define WINDOW_RESET 8'h01
`define PRIO_RESET 1'b0
`define LFSR_RESET 9'h1ff
`define WINDOW_SHIFT 3

// packet kinds on the forward path
`define KIND_POSTED 2'h0
`define KIND_NONPOSTED 2'h1
`define KIND_RESPONSE 2'h2

// transmit slot source codes
`define SRC_NONE 2'h0
`define SRC_FWD 2'h1
`define SRC_LOCAL 2'h2
`define SRC_INFO 2'h3

// rejected read data
`define REJ_DATA_WORD 32'hffffffff

// register map
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define CTRL_RESET 2'h0
`define CTRL_TERM_LSB 0
`define STATUS_HALF_W 16

`endif

// *** logic/unit_rate_counters.v ***
/*
 per-unit forwarding rate counters and denominator capture for one
 traffic direction.
 assumes inc_i is a one-cycle request qualified by ce_i in the same cycle.
*/
`include "link_fair_map.vh"

module unit_rate_counters #(
	parameter UNITS = `UNIT_COUNT,
	parameter UW = `UNIT_ID_W,
	parameter CW = `UNIT_CNT_W,
	parameter TW = `TOTAL_CNT_W
) (
	// clock and reset
	input wire clk_i,
	input wire reset_i,
	input wire ce_i,
	// forwarded packet event
	input wire inc_i,
	input wire [UW-1:0] unit_i,
	// captured denominator
	output wire [TW-1:0] denom_o
);

	reg [CW-1:0] cnt_reg [0:UNITS-1];
	reg [TW-1:0] total_reg;
	reg [TW-1:0] denom_reg;
	integer k;

	assign denom_o = denom_reg;

	always @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			for (k = 0; k < UNITS; k = k + 1) begin
				cnt_reg[k] <= {CW{1'b0}};
			end
			total_reg <= {TW{1'b0}};
			denom_reg <= `DENOM_RESET;
		end else if (ce_i && inc_i) begin
			if (&cnt_reg[unit_i]) begin
				// overflow: keep post-increment total, restart measurement
				denom_reg <= total_reg + {{(TW-1){1'b0}}, 1'b1};
				for (k = 0; k < UNITS; k = k + 1) begin
					cnt_reg[k] <= {CW{1'b0}};
				end
				total_reg <= {TW{1'b0}};
			end else begin
				cnt_reg[unit_i] <= cnt_reg[unit_i] + {{(CW-1){1'b0}}, 1'b1};
				total_reg <= total_reg + {{(TW-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule // unit_rate_counters

// *** logic/link_insertion_fairness_arbiter.v ***
/*
 insertion arbiter and chain-end rejection logic for a tunnel node, two
 independent directions, with an apb register slave for chain-end flags
 and rejection counts.
 assumes all inputs synchronous to CLK_I; forward and local sources hold
 their packet until taken; buffer credit inputs reflect far-end space.
*/
// The implementer's own choices: the APB slave port and the address map.
// Contract
// - zero-unit rejected nonposted: error, nxa, bridge clear
// - nonzero-unit rejected nonposted: bridge set, same unit
// - rejected reads return all-ones requested doublewords
// - rejected responses and posted requests dropped silently
// - two separate fairness instances, no software control
// - thirty-two 3-bit counters, one 8-bit total
// - forwarded packet bumps unit and total counters
// - unit overflow captures total, clears all counters
// - denominator resets to one; insertion paced
// - no forward pending: local packet may go
// - window resets to one, priority to zero
// - forward only: send it, decrement window
// - local only: send it, clear priority
// - both pending: priority picks local, else forward
// - window reaching zero reloads and sets priority
// - nine-bit lfsr x^9+x^4+1 steps per reload
// - window loads (denominator plus lfsr low bits) >> 3
// - info packets bypass fairness counters
// - present only with credit; avoid channel starvation
// - forwarding toward chain-end link is rejected
// - rejected broadcasts silently discarded
`include "link_fair_map.vh"

module link_insertion_fairness_arbiter #(
	parameter UNIT_W = `UNIT_ID_W,
	parameter COUNT_W = 4,
	parameter TAG_W = 5,
	parameter VC_W = 2
) (
	// clock, reset, enable
	input wire CLK_I,
	input wire RESET_I,
	input wire CE_I,
	// apb slave
	input wire PSEL_I,
	input wire PENABLE_I,
	input wire PWRITE_I,
	input wire [7:0] PADDR_I,
	input wire [31:0] PWDATA_I,
	output reg [31:0] PRDATA_O,
	output wire PREADY_O,
	output wire PSLVERR_O,
	// forwarded packets, one lane per direction
	input wire [1:0] FWD_VALID_I,
	input wire [1:0] FWD_CREDIT_I,
	input wire [2*VC_W-1:0] FWD_VC_I,
	input wire [2*UNIT_W-1:0] FWD_UNIT_I,
	input wire [3:0] FWD_KIND_I,
	input wire [1:0] FWD_BCAST_I,
	input wire [1:0] FWD_READ_I,
	input wire [2*COUNT_W-1:0] FWD_COUNT_I,
	input wire [2*TAG_W-1:0] FWD_TAG_I,
	output wire [1:0] FWD_TAKE_O,
	// locally issued packets
	input wire [1:0] LOC_VALID_I,
	input wire [1:0] LOC_CREDIT_I,
	input wire [2*VC_W-1:0] LOC_VC_I,
	output wire [1:0] LOC_TAKE_O,
	// link info packets
	input wire [1:0] INFO_VALID_I,
	output wire [1:0] INFO_TAKE_O,
	// transmit slot record
	output wire [1:0] TX_VALID_O,
	output wire [3:0] TX_SRC_O,
	// rejection responses
	output wire [1:0] REJ_HDR_VALID_O,
	input wire [1:0] REJ_HDR_READY_I,
	output wire [2*UNIT_W-1:0] REJ_UNIT_O,
	output wire [2*TAG_W-1:0] REJ_TAG_O,
	output wire [1:0] REJ_READ_O,
	output wire [1:0] REJ_ERROR_O,
	output wire [1:0] REJ_NXA_O,
	output wire [1:0] REJ_BRIDGE_O,
	output wire [2*COUNT_W-1:0] REJ_COUNT_O,
	output wire [1:0] REJ_DATA_VALID_O,
	input wire [1:0] REJ_DATA_READY_I,
	output wire [63:0] REJ_DATA_O
);

	localparam RJ_IDLE = 2'h0;
	localparam RJ_HDR = 2'h1;
	localparam RJ_DATA = 2'h2;

	// polynomial x^9+x^4+1, shift toward msb
	function [8:0] lfsr_step;
		input [8:0] s;
		begin
			lfsr_step = {s[7:0], s[8] ^ s[3]};
		end
	endfunction

	function [7:0] window_load;
		input [7:0] denom;
		input [2:0] low;
		reg [8:0] sum;
		begin
			sum = {1'b0, denom} + {6'h00, low};
			window_load = {2'h0, sum[8:`WINDOW_SHIFT]};
		end
	endfunction

	// register slave
	reg [1:0] term_reg;
	reg [`STATUS_HALF_W-1:0] rej_cnt_reg [0:1];
	wire [1:0] rej_evt;
	wire apb_access = PSEL_I && PENABLE_I;
	wire hit_ctrl = PADDR_I == `ADDR_CTRL;
	wire hit_status = PADDR_I == `ADDR_STATUS;
	integer n;

	assign PREADY_O = 1'b1;
	assign PSLVERR_O = apb_access && !hit_ctrl && !hit_status;

	always @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			term_reg <= `CTRL_RESET;
			PRDATA_O <= 32'h00000000;
			for (n = 0; n < 2; n = n + 1) begin
				rej_cnt_reg[n] <= {`STATUS_HALF_W{1'b0}};
			end
		end else if (CE_I) begin
			if (apb_access && PWRITE_I && hit_ctrl) begin
				term_reg <= PWDATA_I[`CTRL_TERM_LSB +: 2];
			end
			if (PSEL_I && !PENABLE_I) begin
				if (hit_ctrl) begin
					PRDATA_O <= {30'h00000000, term_reg};
				end else if (hit_status) begin
					PRDATA_O <= {rej_cnt_reg[1], rej_cnt_reg[0]};
				end else begin
					PRDATA_O <= 32'h00000000;
				end
			end
			for (n = 0; n < 2; n = n + 1) begin
				// saturating rejection tally
				if (rej_evt[n] && !(&rej_cnt_reg[n])) begin
					rej_cnt_reg[n] <= rej_cnt_reg[n] + {{(`STATUS_HALF_W-1){1'b0}}, 1'b1};
				end
			end
		end
	end

	// one fully separate fairness engine per direction
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : dir
			wire term = term_reg[g];
			wire f_valid = FWD_VALID_I[g];
			wire [VC_W-1:0] f_vc = FWD_VC_I[g*VC_W +: VC_W];
			wire [UNIT_W-1:0] f_unit = FWD_UNIT_I[g*UNIT_W +: UNIT_W];
			wire [1:0] f_kind = FWD_KIND_I[2*g +: 2];
			wire [VC_W-1:0] l_vc = LOC_VC_I[g*VC_W +: VC_W];
			wire [7:0] denom;

			reg [7:0] window_reg;
			reg prio_reg;
			reg [8:0] lfsr_reg;
			reg tx_valid_reg;
			reg [1:0] tx_src_reg;

			reg [1:0] rj_state_reg;
			reg [UNIT_W-1:0] rj_unit_reg;
			reg [TAG_W-1:0] rj_tag_reg;
			reg rj_read_reg;
			reg rj_bridge_reg;
			reg rj_flag_reg;
			reg [COUNT_W-1:0] rj_count_reg;
			reg [COUNT_W-1:0] rj_beat_reg;

			wire rj_idle = rj_state_reg == RJ_IDLE;
			// info packets own the slot and never touch pacing state
			wire info = INFO_VALID_I[g];
			// keep a forward packet from eating the buffer a prioritised
			// local packet in the same channel is waiting for
			wire vc_hold = prio_reg && LOC_VALID_I[g] && !LOC_CREDIT_I[g] &&
				(f_vc == l_vc);
			wire fwd_req = !term && f_valid && FWD_CREDIT_I[g] && !vc_hold;
			wire loc_req = !term && LOC_VALID_I[g] && LOC_CREDIT_I[g];
			wire send_fwd = CE_I && !info && fwd_req && (!loc_req || !prio_reg);
			wire send_loc = CE_I && !info && loc_req && !send_fwd;
			// toward a chain-end link, forwarded packets are consumed here
			wire rej_take = CE_I && term && f_valid && rj_idle;
			wire rej_np = (f_kind == `KIND_NONPOSTED) && !FWD_BCAST_I[g];

			assign rej_evt[g] = rej_take;
			assign FWD_TAKE_O[g] = send_fwd || rej_take;
			assign LOC_TAKE_O[g] = send_loc;
			assign INFO_TAKE_O[g] = CE_I && info;
			assign TX_VALID_O[g] = tx_valid_reg;
			assign TX_SRC_O[2*g +: 2] = tx_src_reg;

			unit_rate_counters #(
				.UNITS(`UNIT_COUNT),
				.UW(UNIT_W),
				.CW(`UNIT_CNT_W),
				.TW(`TOTAL_CNT_W)
			) rate (
				.clk_i(CLK_I),
				.reset_i(RESET_I),
				.ce_i(CE_I),
				.inc_i(send_fwd),
				.unit_i(f_unit),
				.denom_o(denom)
			);

			always @(posedge CLK_I or posedge RESET_I) begin
				if (RESET_I) begin
					window_reg <= `WINDOW_RESET;
					prio_reg <= `PRIO_RESET;
					lfsr_reg <= `LFSR_RESET;
					tx_valid_reg <= 1'b0;
					tx_src_reg <= `SRC_NONE;
				end else if (CE_I) begin
					tx_valid_reg <= info || send_fwd || send_loc;
					if (info) begin
						tx_src_reg <= `SRC_INFO;
					end else if (send_fwd) begin
						tx_src_reg <= `SRC_FWD;
					end else if (send_loc) begin
						tx_src_reg <= `SRC_LOCAL;
					end else begin
						tx_src_reg <= `SRC_NONE;
					end
					if (send_fwd) begin
						// a load of zero also counts as spent on next decrement
						if (window_reg <= 8'h01) begin
							window_reg <= window_load(denom, lfsr_reg[2:0]);
							prio_reg <= 1'b1;
							lfsr_reg <= lfsr_step(lfsr_reg);
						end else begin
							window_reg <= window_reg - 8'h01;
						end
					end else if (send_loc) begin
						prio_reg <= 1'b0;
					end
				end
			end

			// rejection response sequencer
			always @(posedge CLK_I or posedge RESET_I) begin
				if (RESET_I) begin
					rj_state_reg <= RJ_IDLE;
					rj_unit_reg <= {UNIT_W{1'b0}};
					rj_tag_reg <= {TAG_W{1'b0}};
					rj_read_reg <= 1'b0;
					rj_bridge_reg <= 1'b0;
					rj_flag_reg <= 1'b0;
					rj_count_reg <= {COUNT_W{1'b0}};
					rj_beat_reg <= {COUNT_W{1'b0}};
				end else if (CE_I) begin
					case (rj_state_reg)
						RJ_IDLE: begin
							if (rej_take && rej_np) begin
								rj_state_reg <= RJ_HDR;
								// zero unit answers with unit zero, else echoes it
								rj_unit_reg <= FWD_UNIT_I[g*UNIT_W +: UNIT_W];
								rj_bridge_reg <= |f_unit;
								rj_flag_reg <= 1'b1;
								rj_tag_reg <= FWD_TAG_I[g*TAG_W +: TAG_W];
								rj_read_reg <= FWD_READ_I[g];
								rj_count_reg <= FWD_COUNT_I[g*COUNT_W +: COUNT_W];
								rj_beat_reg <= {COUNT_W{1'b0}};
							end
						end
						RJ_HDR: begin
							if (REJ_HDR_READY_I[g]) begin
								rj_state_reg <= rj_read_reg ? RJ_DATA : RJ_IDLE;
							end
						end
						RJ_DATA: begin
							if (REJ_DATA_READY_I[g]) begin
								if (rj_beat_reg == rj_count_reg) begin
									rj_state_reg <= RJ_IDLE;
								end else begin
									rj_beat_reg <= rj_beat_reg + {{(COUNT_W-1){1'b0}}, 1'b1};
								end
							end
						end
						default: begin
							rj_state_reg <= RJ_IDLE;
						end
					endcase
				end
			end

			assign REJ_HDR_VALID_O[g] = rj_state_reg == RJ_HDR;
			assign REJ_DATA_VALID_O[g] = rj_state_reg == RJ_DATA;
			assign REJ_UNIT_O[g*UNIT_W +: UNIT_W] = rj_unit_reg;
			assign REJ_TAG_O[g*TAG_W +: TAG_W] = rj_tag_reg;
			assign REJ_READ_O[g] = rj_read_reg;
			assign REJ_ERROR_O[g] = rj_flag_reg;
			assign REJ_NXA_O[g] = rj_flag_reg;
			assign REJ_BRIDGE_O[g] = rj_bridge_reg;
			assign REJ_COUNT_O[g*COUNT_W +: COUNT_W] = rj_count_reg;
			assign REJ_DATA_O[32*g +: 32] = `REJ_DATA_WORD;
		end
	endgenerate

endmodule // link_insertion_fairness_arbiter

// *** test/link_fair_props.sv ***
/* checker on direction 0 of the arbiter.
 assumes binding onto the arbiter top. */
module link_fair_props #(
	parameter UNIT_W = 5
) (
	// clock
	input wire logic CLK_I,
	input wire logic RESET_I,
	input wire logic CE_I,
	// slots
	input wire logic [1:0] FWD_VALID_I,
	input wire logic [1:0] FWD_CREDIT_I,
	input wire logic [1:0] LOC_VALID_I,
	input wire logic [1:0] LOC_CREDIT_I,
	input wire logic [1:0] INFO_VALID_I,
	input wire logic [1:0] FWD_TAKE_O,
	input wire logic [1:0] LOC_TAKE_O,
	input wire logic [1:0] INFO_TAKE_O,
	input wire logic [1:0] TX_VALID_O,
	input wire logic [3:0] TX_SRC_O,
	// rejection
	input wire logic [1:0] REJ_HDR_VALID_O,
	input wire logic [1:0] REJ_HDR_READY_I,
	input wire logic [2*UNIT_W-1:0] REJ_UNIT_O,
	input wire logic [1:0] REJ_ERROR_O,
	input wire logic [1:0] REJ_NXA_O,
	input wire logic [1:0] REJ_BRIDGE_O,
	input wire logic [1:0] REJ_DATA_VALID_O,
	input wire logic [63:0] REJ_DATA_O
);
	default clocking @(posedge CLK_I);
	endclocking
	default disable iff (RESET_I);
	chk_info_first:
		assert property (CE_I && INFO_VALID_I[0] |-> INFO_TAKE_O[0] && !FWD_TAKE_O[0])
		else $error("info slot lost");
	chk_local_slot:
		assert property (LOC_TAKE_O[0] |=> TX_VALID_O[0] && TX_SRC_O[1:0] == 2'h2)
		else $error("local slot missing");
	chk_local_credit:
		assert property (LOC_TAKE_O[0] |-> LOC_VALID_I[0] && LOC_CREDIT_I[0])
		else $error("local without credit");
	chk_fwd_credit:
		assert property (TX_VALID_O[0] && TX_SRC_O[1:0] == 2'h1 |-> $past(FWD_CREDIT_I[0]))
		else $error("forward without credit");
	chk_prio_clears:
		assert property (LOC_TAKE_O[0] ##1 (CE_I && FWD_VALID_I[0] && FWD_CREDIT_I[0]
			&& !INFO_VALID_I[0]) |-> FWD_TAKE_O[0])
		else $error("forward not taken after local");
	chk_rej_flags:
		assert property (REJ_HDR_VALID_O[0] |-> REJ_ERROR_O[0] && REJ_NXA_O[0]
			&& REJ_BRIDGE_O[0] == (REJ_UNIT_O[UNIT_W-1:0] != 0))
		else $error("reject flags wrong");
	chk_rej_hold:
		assert property (REJ_HDR_VALID_O[0] && !REJ_HDR_READY_I[0] |=> REJ_HDR_VALID_O[0]
			&& $stable(REJ_UNIT_O))
		else $error("reject header dropped");
	chk_ones_data:
		assert property (REJ_DATA_VALID_O[0] |-> REJ_DATA_O[31:0] == 32'hffffffff)
		else $error("reject data not ones");
	chk_rej_busy:
		assert property (REJ_HDR_VALID_O[0] || REJ_DATA_VALID_O[0] |-> !FWD_TAKE_O[0])
		else $error("forward taken while rejecting");
	cover property (LOC_TAKE_O[0] && FWD_VALID_I[0]);
	cover property (REJ_DATA_VALID_O[0]);
	cover property (REJ_HDR_VALID_O[0] && !REJ_HDR_READY_I[0]);
endmodule // link_fair_props
bind link_insertion_fairness_arbiter link_fair_props #(.UNIT_W(UNIT_W)) props_i (.*);

// *** test/far_node_model.sv ***
/* far chain node: drains rejection responses, promptly or with stalls.
 assumes slow_i changes only between packets. */
module far_node_model (
	// clock and mode
	input wire logic clk_i,
	input wire logic slow_i,
	// readiness
	output logic [1:0] hdr_ready_o = 2'h0,
	output logic [1:0] data_ready_o = 2'h0
);
	logic [1:0] phase_reg = 2'h0;
	always @(posedge clk_i) begin
		phase_reg <= phase_reg + 2'h1;
		hdr_ready_o <= {2{!slow_i || phase_reg == 2'h3}};
		data_ready_o <= {2{!slow_i || phase_reg[0]}};
	end
endmodule // far_node_model

// *** test/tb_link_insertion_fairness_arbiter.sv ***
/* bench: insertion pacing on direction 0, then chain-end rejection.
 assumes the far node model drains rejection responses. */
module tb_link_insertion_fairness_arbiter;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK_I = 0, RESET_I = 1, CE_I = 1, PSEL_I = 0, PENABLE_I = 0, PWRITE_I = 0;
	logic PREADY_O, PSLVERR_O, slow = 0, prio = 0, info, e;
	logic [7:0] PADDR_I = 0, FWD_COUNT_I = 0, REJ_COUNT_O, total = 0, denom = 1, win = 1;
	logic [31:0] PWDATA_I = 0, PRDATA_O, q, tx_q[$], rej_q[$];
	logic [1:0] FWD_VALID_I = 0, FWD_CREDIT_I = 0, FWD_BCAST_I = 0, FWD_READ_I = 0;
	logic [1:0] LOC_VALID_I = 0, LOC_CREDIT_I = 0, INFO_VALID_I = 0, REJ_HDR_READY_I;
	logic [1:0] FWD_TAKE_O, LOC_TAKE_O, INFO_TAKE_O, TX_VALID_O, REJ_HDR_VALID_O;
	logic [1:0] REJ_READ_O, REJ_ERROR_O, REJ_NXA_O, REJ_BRIDGE_O, REJ_DATA_VALID_O, REJ_DATA_READY_I;
	logic [3:0] FWD_VC_I = 0, LOC_VC_I = 0, FWD_KIND_I = 0, TX_SRC_O;
	logic [9:0] FWD_UNIT_I = 0, FWD_TAG_I = 0, REJ_UNIT_O, REJ_TAG_O;
	logic [63:0] REJ_DATA_O;
	logic [2:0] cnt [32] = '{default: 3'h0};
	logic [8:0] lfsr = 9'h1ff;
	logic [4:0] u;
	logic [12:0] p;
	int seed = 32'h88c2936c, err_total = 0, check_count = 0;
	localparam logic [12:0] PKT [6] = '{13'h0c32, 13'h0800, 13'h0c00, 13'h0050, 13'h1070, 13'h0200};

	link_insertion_fairness_arbiter uut (.*);
	far_node_model peer (.clk_i(CLK_I), .slow_i(slow), .hdr_ready_o(REJ_HDR_READY_I),
		.data_ready_o(REJ_DATA_READY_I));

	initial begin
		forever #5 CLK_I = ~CLK_I;
	end

	task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic final_report;
		if (err_total == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		PSEL_I <= 1'b1;
		PWRITE_I <= wr;
		PADDR_I <= a;
		PWDATA_I <= d;
		@(posedge CLK_I);
		PENABLE_I <= 1'b1;
		do @(posedge CLK_I); while (PREADY_O !== 1'b1);
		q = PRDATA_O;
		e = PSLVERR_O;
		PSEL_I <= 1'b0;
		PENABLE_I <= 1'b0;
		@(posedge CLK_I);
	endtask

	task automatic fwd_step;
		if (win <= 8'h1) begin
			win = 8'(({1'b0, denom} + lfsr[2:0]) >> 3);
			prio = 1'b1;
			lfsr = {lfsr[7:0], lfsr[8] ^ lfsr[3]};
		end else
			win = win - 8'h1;
		if (cnt[u] == 3'h7) begin
			denom = total + 8'h1;
			total = 8'h0;
			foreach (cnt[k]) cnt[k] = 3'h0;
		end else begin
			cnt[u] = cnt[u] + 3'h1;
			total = total + 8'h1;
		end
		u = 5'($random(seed));
	endtask

	always @(negedge CLK_I) begin
		if (TX_VALID_O[0] === 1'b1)
			compare("tx_src", tx_q.size() > 0 ? tx_q.pop_front() : 'x, 32'(TX_SRC_O[1:0]));
		if (REJ_HDR_VALID_O[0] === 1'b1 && REJ_HDR_READY_I[0] === 1'b1)
			compare("rej_hdr", rej_q.size() > 0 ? rej_q.pop_front() : 'x, {14'h0, REJ_TAG_O[4:0], REJ_ERROR_O[0],
				REJ_NXA_O[0], REJ_BRIDGE_O[0], REJ_READ_O[0], REJ_UNIT_O[4:0], REJ_COUNT_O[3:0]});
		if (REJ_DATA_VALID_O[0] === 1'b1 && REJ_DATA_READY_I[0] === 1'b1)
			compare("rej_data", rej_q.size() > 0 ? rej_q.pop_front() : 'x, REJ_DATA_O[31:0]);
	end

	initial begin
		#100us;
		err_total++;
		final_report();
	end

	initial begin
		u = 5'($random(seed));
		repeat (10) @(posedge CLK_I);
		RESET_I <= 1'b0;
		FWD_VALID_I <= 2'h1;
		FWD_CREDIT_I <= 2'h1;
		LOC_VALID_I <= 2'h1;
		LOC_CREDIT_I <= 2'h1;
		for (int i = 0; i < 600; i++) begin
			info = (i % 13 == 5);
			INFO_VALID_I <= {1'b0, info};
			FWD_UNIT_I <= {5'h0, u};
			if (info)
				tx_q.push_back(32'h3);
			else if (prio) begin
				tx_q.push_back(32'h2);
				prio = 1'b0;
			end else begin
				tx_q.push_back(32'h1);
				fwd_step();
			end
			@(posedge CLK_I);
		end
		FWD_VALID_I <= 2'h0;
		INFO_VALID_I <= 2'h0;
		repeat (2) tx_q.push_back(32'h2);
		repeat (2) @(posedge CLK_I);
		LOC_VALID_I <= 2'h0;
		apb(1'b1, 8'h00, 32'h1);
		LOC_VALID_I <= 2'h1;
		FWD_CREDIT_I <= 2'h0;
		FWD_VALID_I <= 2'h1;
		for (int i = 0; i < 6; i++) begin
			p = PKT[i];
			slow <= i[0];
			{FWD_KIND_I[1:0], FWD_READ_I[0], FWD_BCAST_I[0], FWD_UNIT_I[4:0], FWD_COUNT_I[3:0]} <= p;
			FWD_TAG_I <= {5'h00, 5'(i + 3)};
			if (p[12:11] == 2'h1) begin
				rej_q.push_back({14'h0, 5'(i + 3), 2'b11, p[8:4] != 5'h0, p[10], p[8:4], p[3:0]});
				if (p[10])
					repeat (p[3:0] + 1) rej_q.push_back(32'hffffffff);
			end
			do @(negedge CLK_I); while (FWD_TAKE_O[0] !== 1'b1);
			@(posedge CLK_I);
		end
		FWD_VALID_I <= 2'h0;
		for (int k = 0; k < 200 && rej_q.size() > 0; k++) @(posedge CLK_I);
		apb(1'b0, 8'h04, 32'h0);
		compare("left", 32'h0, 32'(rej_q.size() + tx_q.size()));
		compare("status", 32'h6, q);
		apb(1'b0, 8'h08, 32'h0);
		compare("unmapped", 32'h1, {31'h0, e});
		final_report();
	end
endmodule // tb_link_insertion_fairness_arbiter
